// [hw/csi_ident_regs.sv]
/*
  Per-buffer identifier registers in standard mapping, AXI4-Lite slave,
  receive capture from the protocol engine and MSB-first arbitration output.
  Assumes bit_tick and bus_rx_bit from the protocol engine synchronous to clk.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "csi_map.svh"

module csi_ident_regs import csi_pkg::*; #(
    parameter int NUM_BUF = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`CSI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CSI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_store,
    input wire logic [$clog2(NUM_BUF)-1:0] rx_buf,
    input wire logic [10:0] rx_frame_identifier,
    input wire logic rx_rtr,
    input wire logic rx_ide,
    input wire logic bit_tick,
    input wire logic bus_rx_bit,
    output logic tx_bit,
    output logic tx_active,
    output logic tx_ext_fmt,
    output logic arb_lost
);
    localparam int BUF_W = $clog2(NUM_BUF);
    localparam int MEM_AW = BUF_W + 2;

    csi_mseq_type mseq_reg;
    csi_tx_type tx_state_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, w_data_reg;
    logic [3:0] w_strb_reg;
    logic [`CSI_ADDR_W-1:0] aw_addr_reg, ar_addr_reg;
    logic rx_pend_reg, rx_rtr_reg, rx_ide_reg;
    logic [BUF_W-1:0] rx_buf_reg, tx_buf_reg;
    logic [10:0] rx_id_reg;
    logic tx_fetch_reg, first_reg, tx_bit_reg, tx_active_reg, ext_reg, lost_reg, done_reg;
    logic [`CSI_ARB_BITS-1:0] shift_reg;
    logic [3:0] cnt_reg;
    logic [7:0] byte0_reg;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr, mem_raddr;
    logic [7:0] mem_wdata, mem_rdata;
    logic wr_go, rd_go, go_rx, go_tx, go_wr, go_rd;
    logic wr_in_buf, rd_in_buf, wr_is_ctl, ctl_go;
    logic [31:0] status_word, ctl_word;

    // address decode: buffer space is buf * 16 + index * 4
    assign wr_in_buf = (aw_addr_reg[11:8] == 4'h0) && (int'(aw_addr_reg[7:4]) < NUM_BUF);
    assign rd_in_buf = (ar_addr_reg[11:8] == 4'h0) && (int'(ar_addr_reg[7:4]) < NUM_BUF);
    assign wr_is_ctl = (aw_addr_reg[11:2] == 10'(`CSI_CTL_ADDR >> 2));
    // address and data both held, previous answer taken
    assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
    assign rd_go = !arready_reg && !rvalid_reg;
    // one memory user per cycle: receive capture first so no frame is dropped
    assign go_rx = (mseq_reg == CSI_M_IDLE) && rx_pend_reg;
    assign go_tx = (mseq_reg == CSI_M_IDLE) && !rx_pend_reg && tx_fetch_reg;
    assign go_wr = (mseq_reg == CSI_M_IDLE) && !rx_pend_reg && !tx_fetch_reg && wr_go;
    assign go_rd = (mseq_reg == CSI_M_IDLE) && !rx_pend_reg && !tx_fetch_reg && !wr_go && rd_go;
    assign ctl_go = go_wr && wr_is_ctl && w_strb_reg[0] && w_data_reg[`CSI_CTL_GO];
    assign status_word = {28'h0000000, ext_reg, done_reg, lost_reg, tx_active_reg};
    assign ctl_word = {24'h000000, 4'(tx_buf_reg), 4'h0};

    // memory port steering
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = 8'h00;
        mem_raddr = '0;
        if (go_rx) begin
            mem_we = 1'b1;
            mem_waddr = {rx_buf_reg, `CSI_IDX_BYTE0};
            mem_wdata = rx_id_reg[10:3];
        end else if (mseq_reg == CSI_M_RX1) begin
            mem_we = 1'b1;
            mem_waddr = {rx_buf_reg, `CSI_IDX_BYTE1};
            mem_wdata = {rx_id_reg[2:0], rx_rtr_reg, rx_ide_reg, 3'h0};
        end else if (go_tx) begin
            mem_raddr = {tx_buf_reg, `CSI_IDX_BYTE0};
        end else if (mseq_reg == CSI_M_TX1) begin
            mem_raddr = {tx_buf_reg, `CSI_IDX_BYTE1};
        end else if (go_wr) begin
            mem_we = wr_in_buf && w_strb_reg[0];
            mem_waddr = {aw_addr_reg[BUF_W+3:4], aw_addr_reg[3:2]};
            mem_wdata = w_data_reg[7:0];
        end else if (go_rd) begin
            mem_raddr = {ar_addr_reg[BUF_W+3:4], ar_addr_reg[3:2]};
        end
    end

    csi_ident_mem #(
        .WIDTH(8),
        .DEPTH(NUM_BUF * 4),
        .AW(MEM_AW)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // write address and data capture; ready returns after the response is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_addr_reg <= `CSI_RST_ADDR;
            w_data_reg <= `CSI_RST_WORD;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_addr_reg <= s_axi_awaddr;
                awready_reg <= 1'b0;
            end else if (bvalid_reg && s_axi_bready) begin
                awready_reg <= 1'b1;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end else if (bvalid_reg && s_axi_bready) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // read address capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_reg <= 1'b1;
            ar_addr_reg <= `CSI_RST_ADDR;
        end else if (s_axi_arvalid && arready_reg) begin
            ar_addr_reg <= s_axi_araddr;
            arready_reg <= 1'b0;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
        end
    end

    // memory sequencer and bus answers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mseq_reg <= CSI_M_IDLE;
            bvalid_reg <= 1'b0;
            bresp_reg <= `CSI_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `CSI_RESP_OKAY;
            rdata_reg <= `CSI_RST_WORD;
            byte0_reg <= 8'h00;
        end else begin
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
            case (mseq_reg)
                CSI_M_IDLE: begin
                    if (go_rx) begin
                        mseq_reg <= CSI_M_RX1;
                    end else if (go_tx) begin
                        mseq_reg <= CSI_M_TX1;
                    end else if (go_wr) begin
                        bvalid_reg <= 1'b1;
                        bresp_reg <= (wr_in_buf || wr_is_ctl) ? `CSI_RESP_OKAY : `CSI_RESP_SLVERR;
                    end else if (go_rd) begin
                        if (rd_in_buf) begin
                            mseq_reg <= CSI_M_BRD; // memory read takes one more cycle
                        end else begin
                            rvalid_reg <= 1'b1;
                            rresp_reg <= `CSI_RESP_OKAY;
                            if (ar_addr_reg[11:2] == 10'(`CSI_STAT_ADDR >> 2)) begin
                                rdata_reg <= status_word;
                            end else if (ar_addr_reg[11:2] == 10'(`CSI_CTL_ADDR >> 2)) begin
                                rdata_reg <= ctl_word;
                            end else begin
                                rdata_reg <= `CSI_RST_WORD;
                                rresp_reg <= `CSI_RESP_SLVERR;
                            end
                        end
                    end
                end
                CSI_M_RX1: mseq_reg <= CSI_M_IDLE;
                CSI_M_TX1: begin
                    byte0_reg <= mem_rdata;
                    mseq_reg <= CSI_M_TX2;
                end
                CSI_M_TX2: mseq_reg <= CSI_M_IDLE;
                CSI_M_BRD: begin
                    rvalid_reg <= 1'b1;
                    rresp_reg <= `CSI_RESP_OKAY;
                    rdata_reg <= {24'h000000, mem_rdata};
                    mseq_reg <= CSI_M_IDLE;
                end
                default: mseq_reg <= CSI_M_IDLE;
            endcase
        end
    end

    // receive capture; a new store wins over the clear of the pending flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_pend_reg <= 1'b0;
            rx_buf_reg <= '0;
            rx_id_reg <= 11'h000;
            rx_rtr_reg <= 1'b0;
            rx_ide_reg <= 1'b0;
        end else if (rx_store) begin
            rx_pend_reg <= 1'b1;
            rx_buf_reg <= rx_buf;
            rx_id_reg <= rx_frame_identifier;
            rx_rtr_reg <= rx_rtr;
            rx_ide_reg <= rx_ide;
        end else if (go_rx) begin
            rx_pend_reg <= 1'b0;
        end
    end

    // transmit: fetch two bytes, then drive the arbitration bits on each bit tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_reg <= CSI_TX_IDLE;
            tx_fetch_reg <= 1'b0;
            tx_buf_reg <= '0;
            shift_reg <= '0;
            cnt_reg <= 4'h0;
            first_reg <= 1'b0;
            tx_bit_reg <= `CSI_RECESSIVE;
            tx_active_reg <= 1'b0;
            ext_reg <= 1'b0;
            lost_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            case (tx_state_reg)
                CSI_TX_IDLE: begin
                    // a start while busy is ignored, software polls the busy bit
                    if (ctl_go) begin
                        tx_state_reg <= CSI_TX_FETCH;
                        tx_fetch_reg <= 1'b1;
                        tx_buf_reg <= w_data_reg[`CSI_CTL_BUF_LSB +: BUF_W];
                        tx_active_reg <= 1'b1;
                        lost_reg <= 1'b0;
                        done_reg <= 1'b0;
                    end
                end
                CSI_TX_FETCH: begin
                    if (go_tx) begin
                        tx_fetch_reg <= 1'b0;
                    end
                    if (mseq_reg == CSI_M_TX2) begin
                        // srr stands in for rtr in extended format, both recessive
                        shift_reg <= {byte0_reg, mem_rdata[`CSI_B1_ID_MSB:`CSI_B1_ID_LSB],
                            mem_rdata[`CSI_B1_IDE] ? `CSI_RECESSIVE : mem_rdata[`CSI_B1_RTR],
                            mem_rdata[`CSI_B1_IDE]};
                        ext_reg <= mem_rdata[`CSI_B1_IDE];
                        cnt_reg <= `CSI_ARB_CNT_INIT;
                        first_reg <= 1'b1;
                        tx_state_reg <= CSI_TX_SHIFT;
                    end
                end
                CSI_TX_SHIFT: begin
                    if (bit_tick) begin
                        if (!first_reg && tx_bit_reg && !bus_rx_bit) begin
                            lost_reg <= 1'b1;
                            tx_bit_reg <= `CSI_RECESSIVE;
                            tx_active_reg <= 1'b0;
                            tx_state_reg <= CSI_TX_IDLE;
                        end else if (!first_reg && cnt_reg == `CSI_ARB_CNT_LAST) begin
                            done_reg <= 1'b1;
                            tx_bit_reg <= `CSI_RECESSIVE;
                            tx_active_reg <= 1'b0;
                            tx_state_reg <= CSI_TX_IDLE;
                        end else begin
                            tx_bit_reg <= shift_reg[`CSI_ARB_BITS-1];
                            shift_reg <= {shift_reg[`CSI_ARB_BITS-2:0], 1'b0};
                            if (!first_reg) begin
                                cnt_reg <= cnt_reg - 4'h1;
                            end
                            first_reg <= 1'b0;
                        end
                    end
                end
                default: tx_state_reg <= CSI_TX_IDLE;
            endcase
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign tx_bit = tx_bit_reg;
    assign tx_active = tx_active_reg;
    assign tx_ext_fmt = ext_reg;
    assign arb_lost = lost_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_load;
        mseq_reg == CSI_M_TX2;
    endsequence
    sequence s_lose;
        tx_state_reg == CSI_TX_SHIFT && bit_tick && !first_reg && tx_bit_reg && !bus_rx_bit;
    endsequence

    property p_rx_high_byte;
        go_rx |-> mem_we && mem_wdata == rx_id_reg[10:3] && mem_waddr[1:0] == `CSI_IDX_BYTE0;
    endproperty
    a_rx_high_byte: assert property (p_rx_high_byte) else $error("byte 0 write wrong");
    property p_rx_next_byte;
        go_rx |=> mem_we && mem_waddr[1:0] == `CSI_IDX_BYTE1 && mem_wdata[7:5] == $past(rx_id_reg[2:0]);
    endproperty
    a_rx_next_byte: assert property (p_rx_next_byte) else $error("byte 1 id bits wrong");
    property p_rx_rtr;
        go_rx |=> mem_wdata[`CSI_B1_RTR] == $past(rx_rtr_reg);
    endproperty
    a_rx_rtr: assert property (p_rx_rtr) else $error("received rtr not stored");
    property p_rx_ide;
        go_rx |=> mem_wdata[`CSI_B1_IDE] == $past(rx_ide_reg);
    endproperty
    a_rx_ide: assert property (p_rx_ide) else $error("received ide not stored");
    property p_msb_first;
        tx_state_reg == CSI_TX_SHIFT && bit_tick && first_reg |=> tx_bit_reg == byte0_reg[7];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not id 10");
    property p_lose;
        s_lose |=> arb_lost && tx_bit_reg && tx_state_reg == CSI_TX_IDLE;
    endproperty
    a_lose: assert property (p_lose) else $error("lost arbitration not taken");
    property p_tx_rtr;
        s_load ##0 !mem_rdata[`CSI_B1_IDE] |=> shift_reg[1] == $past(mem_rdata[`CSI_B1_RTR]);
    endproperty
    a_tx_rtr: assert property (p_tx_rtr) else $error("rtr to send wrong");
    property p_tx_fmt;
        s_load |=> tx_ext_fmt == $past(mem_rdata[`CSI_B1_IDE]) && shift_reg[0] == tx_ext_fmt;
    endproperty
    a_tx_fmt: assert property (p_tx_fmt) else $error("format select wrong");
    property p_ignored_bits;
        s_load |=> shift_reg[12:2] == {$past(byte0_reg), $past(mem_rdata[7:5])};
    endproperty
    a_ignored_bits: assert property (p_ignored_bits) else $error("unused bits leaked");
endmodule : csi_ident_regs

// [hw/csi_map.svh]
/*
  Register offsets, field positions, reset values and counts of the
  standard-mapping identifier register block.
  Assumes inclusion by bare name from the package and the main module.
*/
`ifndef CSI_MAP_SVH
`define CSI_MAP_SVH

`define CSI_ADDR_W 12
// register indices inside one buffer, byte address = 4 * index
`define CSI_IDX_BYTE0 2'h0
`define CSI_IDX_BYTE1 2'h1
`define CSI_IDX_BYTE2 2'h2
`define CSI_IDX_BYTE3 2'h3
// own control and status words, above the buffer space
`define CSI_CTL_ADDR 12'h100
`define CSI_STAT_ADDR 12'h104
`define CSI_CTL_GO 0
`define CSI_CTL_BUF_LSB 4
`define CSI_STAT_BUSY 0
`define CSI_STAT_LOST 1
`define CSI_STAT_DONE 2
`define CSI_STAT_EXT 3
// second identifier byte fields
`define CSI_B1_ID_MSB 7
`define CSI_B1_ID_LSB 5
`define CSI_B1_RTR 4
`define CSI_B1_IDE 3
// arbitration serialisation: 11 id bits, rtr or srr, ide
`define CSI_ARB_BITS 13
`define CSI_ARB_CNT_LAST 4'h0
`define CSI_ARB_CNT_INIT 4'hC
`define CSI_RECESSIVE 1'b1
`define CSI_RESP_OKAY 2'h0
`define CSI_RESP_SLVERR 2'h2
`define CSI_RST_WORD 32'h00000000
`define CSI_RST_ADDR 12'h000

`endif

// [hw/csi_pkg.sv]
/*
  Types of the standard-mapping identifier register block.
  Assumes csi_map.svh on the include path.
*/
`include "csi_map.svh"

package csi_pkg;

    // memory port sequencer
    typedef enum logic [2:0] {
        CSI_M_IDLE = 3'b000,
        CSI_M_RX1 = 3'b001,
        CSI_M_TX1 = 3'b010,
        CSI_M_TX2 = 3'b011,
        CSI_M_BRD = 3'b100
    } csi_mseq_type;

    // transmit arbitration sequencer
    typedef enum logic [1:0] {
        CSI_TX_IDLE = 2'b00,
        CSI_TX_FETCH = 2'b01,
        CSI_TX_SHIFT = 2'b10
    } csi_tx_type;

endpackage : csi_pkg

// [hw/csi_ident_mem.sv]
/*
  Identifier byte store: one write port, one read port, read data registered.
  Assumes a single clock; contents have no reset value.
*/
`timescale 1ns/10ps

module csi_ident_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // write and registered read, read-before-write on a shared address
    always_ff @(posedge clk) begin
        if (we) begin
            mem_reg[waddr] <= wdata;
        end
        rdata <= mem_reg[raddr];
    end
endmodule : csi_ident_mem

// [verif/csi_engine_model.sv]
/*
  Behavioural protocol engine and bus: bit timing, wired-AND bus with one
  rival node, record of the arbitration bits the block drives on tx_bit.
  Assumes tx_bit and tx_active from the block and the same clock.
*/
`timescale 1ns/10ps

module csi_engine_model #(
    parameter int TICK_DIV = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_bit,
    input wire logic tx_active,
    input wire logic [12:0] rival_word,
    output logic bit_tick,
    output logic bus_rx_bit,
    output logic [12:0] sent_bits
);
    logic [3:0] div_cnt;
    logic [3:0] tick_num;
    logic [12:0] rival_sh;
    logic rival_on;
    logic bus_level;

    // bit timing stands still outside a frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst || !tx_active) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= (div_cnt == 4'(TICK_DIV - 1)) ? 4'h0 : div_cnt + 4'h1;
        end
    end
    assign bit_tick = tx_active && (div_cnt == 4'(TICK_DIV - 1));
    // dominant wins on the wire; a rival that lost stops driving
    assign bus_level = tx_bit & (!rival_on | rival_sh[12]);
    // between ticks the line is not held, so show the inverse
    assign bus_rx_bit = bit_tick ? bus_level : !bus_level;

    // first tick only starts the frame; later ticks close a bit time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_num <= 4'h0;
            rival_sh <= 13'h1FFF;
            rival_on <= 1'b0;
            sent_bits <= 13'h0000;
        end else if (!tx_active) begin
            tick_num <= 4'h0;
            rival_sh <= rival_word;
            rival_on <= 1'b1;
        end else if (bit_tick) begin
            tick_num <= tick_num + 4'h1;
            if (tick_num != 4'h0) begin
                sent_bits <= {sent_bits[11:0], tx_bit};
                rival_sh <= {rival_sh[11:0], 1'b1};
                if (rival_sh[12] && !bus_level) rival_on <= 1'b0;
            end
        end
    end
endmodule : csi_engine_model

// [verif/test_can_std_identifier_regs.sv]
/*
  Self-checking bench: register access over AXI4-Lite, receive capture,
  arbitration output and arbitration loss against a rival node.
  Assumes the package, map header and engine model compiled before it.
*/
`timescale 1ns/10ps

module test_can_std_identifier_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic rx_store = 1'b0;
    logic [2:0] rx_buf = 3'h0;
    logic [10:0] rx_id = 11'h000;
    logic rx_rtr = 1'b0;
    logic rx_ide = 1'b0;
    logic bit_tick, bus_rx_bit, tx_bit, tx_active, tx_ext_fmt, arb_lost;
    logic [12:0] rival_word = 13'h1FFF;
    logic [12:0] sent_bits;
    logic [31:0] d;
    logic [1:0] r;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    csi_ident_regs #(.NUM_BUF(8)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_store(rx_store),
        .rx_buf(rx_buf), .rx_frame_identifier(rx_id), .rx_rtr(rx_rtr), .rx_ide(rx_ide),
        .bit_tick(bit_tick), .bus_rx_bit(bus_rx_bit), .tx_bit(tx_bit), .tx_active(tx_active),
        .tx_ext_fmt(tx_ext_fmt), .arb_lost(arb_lost));
    csi_engine_model #(.TICK_DIV(8)) engine (.clk(clk), .rst(rst), .tx_bit(tx_bit), .tx_active(tx_active),
        .rival_word(rival_word), .bit_tick(bit_tick), .bus_rx_bit(bus_rx_bit), .sent_bits(sent_bits));

    always #10 clk = ~clk;

    // hang guard, a few thousand cycles above the longest run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // address and data offered together, each released once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, v};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic t_regs();
        logic [7:0] pat [4] = '{8'hA5, 8'h5F, 8'hC3, 8'h3C};
        for (int i = 0; i < 4; i++) wr(12'h030 + 12'(4 * i), pat[i], 4'h1, r);
        for (int i = 0; i < 4; i++) begin
            rd(12'h030 + 12'(4 * i), d, r);
            chk(d, {24'h000000, pat[i]});
        end
        wr(12'h030, 8'h00, 4'h0, r);
        rd(12'h030, d, r);
        chk(d, 32'h000000A5);
        wr(12'h108, 8'h11, 4'h1, r);
        chk(r, 2'h2);
        rd(12'h0F0, d, r);
        chk({d[29:0], r}, 32'h00000002);
        $display("register access test done");
    endtask : t_regs

    // engine hands a received identifier to one buffer
    task automatic t_rx(input logic [2:0] b, input logic [10:0] id, input logic rtr, input logic ide);
        @(posedge clk);
        rx_store <= 1'b1;
        rx_buf <= b;
        rx_id <= id;
        rx_rtr <= rtr;
        rx_ide <= ide;
        @(posedge clk);
        rx_store <= 1'b0;
        repeat (3) @(posedge clk);
        rd({5'h00, b, 4'h0}, d, r);
        chk(d, {24'h000000, id[10:3]});
        rd({5'h00, b, 4'h4}, d, r);
        chk(d, {24'h000000, id[2:0], rtr, ide, 3'b000});
        $display("receive capture test done");
    endtask : t_rx

    // low bits of byte 1 and byte 2 filled with ones, none may reach the wire
    task automatic t_tx(input logic [2:0] b, input logic [10:0] id, input logic rtr, input logic ide,
        input logic [12:0] rw, input logic lose);
        int n;
        wr({5'h00, b, 4'h0}, id[10:3], 4'h1, r);
        wr({5'h00, b, 4'h4}, {id[2:0], rtr, ide, 3'b111}, 4'h1, r);
        wr({5'h00, b, 4'h8}, 8'hFF, 4'h1, r);
        rival_word <= rw;
        wr(12'h100, {1'b0, b, 4'h1}, 4'h1, r);
        repeat (2) @(posedge clk);
        chk(tx_active, 1'b1);
        n = 0;
        while (tx_active === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(arb_lost, lose);
        chk(tx_bit, 1'b1);
        rd(12'h104, d, r);
        if (lose) begin
            chk(d[1:0], 2'b10);
        end else begin
            chk(sent_bits, {id, rtr | ide, ide});
            chk(tx_ext_fmt, ide);
            chk(d[3:0], {ide, 3'b100});
        end
        $display("transmit test done");
    endtask : t_tx

    initial begin
        repeat (3) @(posedge clk);
        chk(tx_bit, 1'b1);
        rst <= 1'b0;
        t_regs();
        t_rx(3'h3, 11'h5A3, 1'b1, 1'b0);
        t_rx(3'h5, 11'h2CA, 1'b0, 1'b1);
        rd(12'h038, d, r);
        chk(d, 32'h000000C3);
        t_tx(3'h2, 11'h6B5, 1'b1, 1'b0, 13'h1FFF, 1'b0);
        t_tx(3'h4, 11'h2CA, 1'b0, 1'b1, 13'h1FFF, 1'b0);
        t_tx(3'h6, 11'h6B5, 1'b0, 1'b0, {11'h6B4, 2'b00}, 1'b1);
        t_tx(3'h6, 11'h3A0, 1'b0, 1'b0, {11'h3A1, 2'b00}, 1'b0);
        stop_test();
    end
endmodule : test_can_std_identifier_regs
